// *** rtl/alo_pkg.sv ***
// Package for the accumulator add and logic datapath: offsets, field layout, opcodes, types.
// Assumes a 32-bit APB slave with 12-bit byte addresses in front of the datapath.
package alo_pkg;

  // Widths of the datapath
  localparam int unsigned ALO_DW = 8;
  localparam int unsigned ALO_IW = 14;
  localparam int unsigned ALO_PAW = 12;

  // Register byte offsets
  localparam logic [11:0] ALO_INSTR_OFS = 12'h000;
  localparam logic [11:0] ALO_ACC_OFS = 12'h004;
  localparam logic [11:0] ALO_FLAGS_OFS = 12'h008;
  localparam logic [11:0] ALO_STAT_OFS = 12'h00c;
  localparam logic [11:0] ALO_FADDR_OFS = 12'h010;
  localparam logic [11:0] ALO_FDATA_OFS = 12'h014;

  // Flag bit positions in the flags register
  localparam int unsigned ALO_FLG_C = 0;
  localparam int unsigned ALO_FLG_HC = 1;
  localparam int unsigned ALO_FLG_Z = 2;

  // Status register bit positions
  localparam int unsigned ALO_STAT_ILL = 0;
  localparam int unsigned ALO_STAT_DST = 1;

  // Instruction fields
  localparam int unsigned ALO_DEST_BIT = 7;

  // Opcode patterns (upper bits of the 14-bit word)
  localparam logic [4:0] ALO_SUM_LIT_OPC = 5'h1f;
  localparam logic [5:0] ALO_MASK_LIT_OPC = 6'h39;
  localparam logic [5:0] ALO_SUM_REG_OPC = 6'h07;
  localparam logic [5:0] ALO_MASK_REG_OPC = 6'h05;

  // Values after reset
  localparam logic [7:0] ALO_ACC_RST = 8'h00;
  localparam logic [2:0] ALO_FLG_RST = 3'h0;
  localparam logic [13:0] ALO_INSTR_RST = 14'h0000;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_SUM_LITERAL_TO_ACC,
    OP_SUM_ACC_WITH_REG,
    OP_MASK_ACC_BY_LITERAL,
    OP_MASK_ACC_WITH_REG
  } alo_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_FETCH,
    ST_DONE
  } alo_state_t;

  // Opcode decode; bit 8 is a don't-care for the literal add
  function automatic alo_op_t alo_decode(input logic [13:0] ins);
    alo_op_t op;
    op = OP_NONE;
    if (ins[13:9] == ALO_SUM_LIT_OPC) op = OP_SUM_LITERAL_TO_ACC;
    else if (ins[13:8] == ALO_MASK_LIT_OPC) op = OP_MASK_ACC_BY_LITERAL;
    else if (ins[13:8] == ALO_SUM_REG_OPC) op = OP_SUM_ACC_WITH_REG;
    else if (ins[13:8] == ALO_MASK_REG_OPC) op = OP_MASK_ACC_WITH_REG;
    return op;
  endfunction

endpackage

// *** rtl/alo_mem_if.sv ***
// Interface between the datapath core and its file-register store.
// Assumes both ends run on the one core clock.
`timescale 1ns/1ps
interface alo_mem_if #(
  parameter int unsigned AW = 7,
  parameter int unsigned DW = 8
);
  logic we;
  logic re;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport core (output we, output re, output addr, output wdata, input rdata);
  modport store (input we, input re, input addr, input wdata, output rdata);
endinterface

// *** rtl/alo_file_mem.sv ***
// File-register store: single port, registered read data one cycle after re.
// Assumes the core never asks for read and write of one address in the same cycle.
`timescale 1ns/1ps
module alo_file_mem #(
  parameter int unsigned AW = 7,
  parameter int unsigned DW = 8
) (
  input wire logic clk,
  input wire logic rst,
  alo_mem_if.store m
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;

  if (AW < 1 || DW < 1) begin : g_chk
    $error("alo_file_mem: AW and DW must be at least 1");
  end

  // Read data capture; held when no read is asked
  always_comb begin
    rdata_d = m.re ? mem_q[m.addr] : rdata_q;
  end

  // Storage has no reset, read register has
  always_ff @(posedge clk) begin
    if (m.we) begin
      mem_q[m.addr] <= m.wdata;
    end
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign m.rdata = rdata_q;
endmodule // alo_file_mem

// *** rtl/alo_core.sv ***
// Accumulator add/AND datapath with its file registers, reached over APB.
// Assumes an APB master on clk; one instruction word is issued per write.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module alo_core #(
  parameter int unsigned AW = 7
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [alo_pkg::ALO_PAW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic [7:0] acc_val,
  output logic [2:0] flags_val
);
  import alo_pkg::*;

  if (AW < 1 || AW > 7) begin : g_chk
    $error("alo_core: AW must be 1..7, the register field is 7 bits");
  end

  alo_state_t st_q, st_d;
  logic [7:0] acc_q, acc_d;
  logic [2:0] flg_q, flg_d;
  logic [13:0] ins_q, ins_d;
  logic [AW-1:0] fad_q, fad_d;
  logic ill_q, ill_d;
  logic dst_q, dst_d;
  logic rdy_q, rdy_d;
  logic [31:0] rdat_q, rdat_d;
  logic err_q, err_d;

  logic mem_we_c;
  logic mem_re_c;
  logic [AW-1:0] mem_addr_c;
  logic [7:0] mem_wdata_c;
  logic [7:0] mem_rdata;

  logic acc_req;
  logic wr_lane0;
  logic wr_lane01;
  alo_op_t cur_op;
  logic [7:0] opnd;
  logic [8:0] sum9;
  logic [4:0] hsum5;
  logic [7:0] res_c;
  logic [2:0] nflg_c;

  alo_mem_if #(.AW(AW), .DW(8)) mem_bus ();

  alo_file_mem #(.AW(AW), .DW(8)) u_mem (
    .clk(clk),
    .rst(rst),
    .m(mem_bus.store)
  );

  // Memory port wiring
  assign mem_bus.we = mem_we_c;
  assign mem_bus.re = mem_re_c;
  assign mem_bus.addr = mem_addr_c;
  assign mem_bus.wdata = mem_wdata_c;
  assign mem_rdata = mem_bus.rdata;

  // Access decode; only the idle state takes a new access
  assign acc_req = psel && penable && (st_q == ST_IDLE);
  assign wr_lane0 = pstrb[0];
  assign wr_lane01 = pstrb[0] && pstrb[1];

  // Operand and opcode come from the bus when idle; when executing, opcode from the latched word, operand from the store read data
  always_comb begin
    if (st_q == ST_EXEC) begin
      cur_op = alo_decode(ins_q);
      opnd = mem_rdata;
    end else begin
      cur_op = alo_decode(pwdata[13:0]);
      opnd = pwdata[7:0];
    end
  end

  // Shared adder and mask; flags follow the op class
  always_comb begin
    sum9 = {1'b0, acc_q} + {1'b0, opnd};
    hsum5 = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]};
    res_c = 8'h00;
    nflg_c = flg_q;
    case (cur_op)
      OP_SUM_LITERAL_TO_ACC, OP_SUM_ACC_WITH_REG: begin
        res_c = sum9[7:0];
        nflg_c[ALO_FLG_C] = sum9[8];
        nflg_c[ALO_FLG_HC] = hsum5[4];
        nflg_c[ALO_FLG_Z] = (sum9[7:0] == 8'h00);
      end
      OP_MASK_ACC_BY_LITERAL, OP_MASK_ACC_WITH_REG: begin
        res_c = acc_q & opnd;
        nflg_c[ALO_FLG_Z] = ((acc_q & opnd) == 8'h00);
      end
      default: begin
        res_c = 8'h00;
      end
    endcase
  end

  // Sequencer: literal ops finish at once, file ops read the store first
  always_comb begin
    st_d = st_q;
    acc_d = acc_q;
    flg_d = flg_q;
    ins_d = ins_q;
    fad_d = fad_q;
    ill_d = ill_q;
    dst_d = dst_q;
    rdy_d = 1'b0;
    rdat_d = rdat_q;
    err_d = 1'b0;
    mem_we_c = 1'b0;
    mem_re_c = 1'b0;
    mem_addr_c = fad_q;
    mem_wdata_c = pwdata[7:0];
    case (st_q)
      ST_IDLE: begin
        if (acc_req) begin
          st_d = ST_DONE;
          rdy_d = 1'b1;
          rdat_d = 32'h0000_0000;
          case (paddr)
            ALO_INSTR_OFS: begin
              if (!pwrite) begin
                rdat_d = {18'h0_0000, ins_q};
              end else if (!wr_lane01) begin
                err_d = 1'b1; // Partial instruction word is refused
              end else begin
                ins_d = pwdata[13:0];
                case (cur_op)
                  OP_SUM_LITERAL_TO_ACC, OP_MASK_ACC_BY_LITERAL: begin
                    acc_d = res_c;
                    flg_d = nflg_c;
                    dst_d = 1'b0;
                  end
                  OP_SUM_ACC_WITH_REG, OP_MASK_ACC_WITH_REG: begin
                    mem_re_c = 1'b1;
                    mem_addr_c = pwdata[AW-1:0];
                    st_d = ST_EXEC;
                    rdy_d = 1'b0;
                  end
                  default: begin
                    ill_d = 1'b1; // Unknown word: only the latched instruction word and the sticky flag change
                  end
                endcase
              end
            end
            ALO_ACC_OFS: begin
              if (pwrite && wr_lane0) acc_d = pwdata[7:0];
              rdat_d = {24'h00_0000, acc_q};
            end
            ALO_FLAGS_OFS: begin
              if (pwrite && wr_lane0) flg_d = pwdata[2:0];
              rdat_d = {29'h0000_0000, flg_q};
            end
            ALO_STAT_OFS: begin
              // Write one clears the illegal flag
              if (pwrite && wr_lane0 && pwdata[ALO_STAT_ILL]) ill_d = 1'b0;
              rdat_d = {30'h0000_0000, dst_q, ill_q};
            end
            ALO_FADDR_OFS: begin
              if (pwrite && wr_lane0) fad_d = pwdata[AW-1:0];
              rdat_d = 32'(fad_q);
            end
            ALO_FDATA_OFS: begin
              if (pwrite) begin
                mem_we_c = wr_lane0;
              end else begin
                mem_re_c = 1'b1;
                st_d = ST_FETCH;
                rdy_d = 1'b0;
              end
            end
            default: begin
              err_d = 1'b1; // Unmapped address
            end
          endcase
        end
      end
      ST_EXEC: begin
        mem_addr_c = ins_q[AW-1:0];
        mem_wdata_c = res_c;
        flg_d = nflg_c;
        dst_d = ins_q[ALO_DEST_BIT];
        if (ins_q[ALO_DEST_BIT]) begin
          mem_we_c = 1'b1;
        end else begin
          acc_d = res_c;
        end
        st_d = ST_DONE;
        rdy_d = 1'b1;
        rdat_d = 32'h0000_0000;
      end
      ST_FETCH: begin
        rdat_d = {24'h00_0000, mem_rdata};
        st_d = ST_DONE;
        rdy_d = 1'b1;
      end
      ST_DONE: begin
        st_d = ST_IDLE; // Master sees pready here and closes the access
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      acc_q <= ALO_ACC_RST;
      flg_q <= ALO_FLG_RST;
      ins_q <= ALO_INSTR_RST;
      fad_q <= '0;
      ill_q <= 1'b0;
      dst_q <= 1'b0;
      rdy_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else begin
      st_q <= st_d;
      acc_q <= acc_d;
      flg_q <= flg_d;
      ins_q <= ins_d;
      fad_q <= fad_d;
      ill_q <= ill_d;
      dst_q <= dst_d;
      rdy_q <= rdy_d;
      rdat_q <= rdat_d;
      err_q <= err_d;
    end
  end

  assign pready = rdy_q;
  assign prdata = rdat_q;
  assign pslverr = err_q;
  assign acc_val = acc_q;
  assign flags_val = flg_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic lit_go;
  alo_op_t ex_op;
  assign lit_go = acc_req && pwrite && (paddr == ALO_INSTR_OFS) && wr_lane01;
  assign ex_op = alo_decode(ins_q);

  sum_lit_acc_a: assert property (lit_go && pwdata[13:9] == 5'h1f |=>
    acc_q == 8'($past(acc_q) + $past(pwdata[7:0])) && pready)
    else $error("literal add result wrong");

  mask_lit_acc_a: assert property (lit_go && pwdata[13:8] == 6'h39 |=>
    acc_q == ($past(acc_q) & $past(pwdata[7:0])) && flg_q[1:0] == $past(flg_q[1:0]))
    else $error("literal AND result or flags wrong");

  file_fetch_a: assert property (lit_go && pwdata[13:8] == 6'h07 |->
    mem_re_c && mem_addr_c == pwdata[AW-1:0] ##1 st_q == ST_EXEC ##1 pready)
    else $error("register add did not fetch the operand");

  dest_acc_a: assert property (st_q == ST_EXEC && !ins_q[7] |->
    !mem_we_c ##1 acc_q == $past(res_c))
    else $error("result did not reach accumulator");

  dest_reg_a: assert property (st_q == ST_EXEC && ins_q[7] |->
    mem_we_c && mem_addr_c == ins_q[AW-1:0] && mem_wdata_c == res_c ##1 $stable(acc_q))
    else $error("result did not reach register or accumulator moved");

  zero_flag_a: assert property (st_q == ST_EXEC |=>
    flg_q[2] == ($past(res_c) == 8'h00))
    else $error("zero flag wrong");

  half_carry_a: assert property (st_q == ST_EXEC && ex_op == OP_SUM_ACC_WITH_REG |=>
    flg_q[1] == (5'({1'b0, $past(acc_q[3:0])} + {1'b0, $past(mem_rdata[3:0])}) > 5'h0f))
    else $error("half carry wrong");

  mask_reg_flags_a: assert property (st_q == ST_EXEC && ex_op == OP_MASK_ACC_WITH_REG |=>
    flg_q[1:0] == $past(flg_q[1:0]))
    else $error("register AND touched carry flags");

  answer_time_a: assert property (acc_req |-> ##[1:2] pready)
    else $error("APB answer late");
endmodule // alo_core

// *** bench/acc_add_and_logic_ops_tb_top.sv ***
// Self-checking bench for the accumulator add/AND datapath, driven as an APB master.
// Assumes alo_core answers every access with one pready pulse, in request order.
`timescale 1ns/1ps
module acc_add_and_logic_ops_tb_top;
  import alo_pkg::*;
  typedef struct packed {logic rd; logic err; logic [31:0] dat;} alo_note_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ALO_PAW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic [7:0] acc_val;
  logic [2:0] flags_val;
  alo_note_t notes[$];
  int err_total = 0;
  int samples_checked = 0;
  logic [31:0] lfsr_s = 32'h3aae2cda;
  logic dst_exp = 1'b0;

  // Clock, 4 ns period
  always #2 clk = ~clk;

  alo_core uut (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .acc_val(acc_val),
    .flags_val(flags_val)
  );

  // Pseudo-random source, fixed seed so runs repeat
  function automatic logic [31:0] rnd();
    lfsr_s = {lfsr_s[30:0], lfsr_s[31] ^ lfsr_s[21] ^ lfsr_s[1] ^ lfsr_s[0]};
    return lfsr_s;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Answer watcher: oldest note pairs with each completed access
  always @(posedge clk) begin
    alo_note_t n;
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        chk("unexpected answer", 32'h0, 32'h1);
      end else begin
        n = notes.pop_front();
        chk("pslverr", {31'h0, n.err}, {31'h0, pslverr});
        if (n.rd) chk("prdata", n.dat, prdata);
      end
    end
  end

  // One APB access; request held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] wd, input logic [3:0] sb,
                      input logic [31:0] ed, input logic ee);
    int n;
    notes.push_back('{rd: !w, err: ee, dat: ed});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    pstrb <= sb;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    xfer(1'b1, ad, wd, 4'hf, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [11:0] ad, input logic [31:0] ed);
    xfer(1'b0, ad, 32'h0, 4'hf, ed, 1'b0);
  endtask

  // Kinds: 0 literal add, 1 register add, 2 literal AND, 3 register AND
  task automatic run_op(input int kind, input logic d, input logic [6:0] f, input logic [7:0] a,
                        input logic [7:0] v, input logic [2:0] fl);
    logic [8:0] s;
    logic [7:0] r;
    logic hc;
    logic [2:0] ef;
    logic to_reg;
    logic [13:0] ins;
    s = {1'b0, a} + {1'b0, v};
    hc = ({1'b0, a[3:0]} + {1'b0, v[3:0]}) > 5'h0f;
    r = (kind < 2) ? s[7:0] : (a & v);
    ef = (kind < 2) ? {r == 8'h00, hc, s[8]} : {r == 8'h00, fl[1:0]};
    to_reg = kind[0] && d;
    case (kind)
      0: ins = {ALO_SUM_LIT_OPC, d, v};
      1: ins = {ALO_SUM_REG_OPC, d, f};
      2: ins = {ALO_MASK_LIT_OPC, v};
      default: ins = {ALO_MASK_REG_OPC, d, f};
    endcase
    wr(ALO_FLAGS_OFS, {29'h0, fl});
    wr(ALO_ACC_OFS, {24'h0, a});
    wr(ALO_FADDR_OFS, {25'h0, f});
    wr(ALO_FDATA_OFS, {24'h0, v});
    wr(ALO_INSTR_OFS, {18'h0, ins});
    rd(ALO_ACC_OFS, {24'h0, to_reg ? a : r});
    rd(ALO_FLAGS_OFS, {29'h0, ef});
    rd(ALO_FDATA_OFS, {24'h0, to_reg ? r : v});
    chk("acc_val", {24'h0, to_reg ? a : r}, {24'h0, acc_val});
    chk("flags_val", {29'h0, ef}, {29'h0, flags_val});
    rd(ALO_STAT_OFS, {30'h0, to_reg, 1'b0});
    rd(ALO_INSTR_OFS, {18'h0, ins});
    // Destination bit that the last instruction left behind
    dst_exp = to_reg;
  endtask

  // Main sequence
  initial begin
    logic [31:0] r;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(ALO_ACC_OFS, 32'h0);
    rd(ALO_FLAGS_OFS, 32'h0);
    $display("test reset done");
    run_op(0, 1'b0, 7'h00, 8'h10, 8'h15, 3'h0);
    run_op(0, 1'b1, 7'h00, 8'h0f, 8'hf1, 3'h0);
    run_op(2, 1'b0, 7'h00, 8'ha3, 8'h5f, 3'h3);
    run_op(1, 1'b0, 7'h7f, 8'h17, 8'hc2, 3'h0);
    run_op(1, 1'b1, 7'h00, 8'hff, 8'h01, 3'h0);
    run_op(3, 1'b1, 7'h7f, 8'h17, 8'hc2, 3'h7);
    $display("test examples done");
    // Random operands over every kind, both destinations
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      run_op(i % 4, r[0], r[7:1], r[15:8], r[23:16], r[26:24]);
    end
    $display("test random done");
    // Lane 0 missing, partial instruction word, unknown word: none may change the accumulator or flags
    wr(ALO_ACC_OFS, 32'h3c);
    xfer(1'b1, ALO_ACC_OFS, 32'h55, 4'he, 32'h0, 1'b0);
    // Instruction word without both low lanes is refused with an error
    xfer(1'b1, ALO_INSTR_OFS, 32'h3e01, 4'h1, 32'h0, 1'b1);
    wr(ALO_INSTR_OFS, 32'h0);
    rd(ALO_ACC_OFS, 32'h3c);
    chk("flags_val", {29'h0, ALO_FLG_RST}, {29'h0, flags_val});
    // Unknown word sets the sticky flag; write one clears it
    rd(ALO_STAT_OFS, {30'h0, dst_exp, 1'b1});
    wr(ALO_STAT_OFS, 32'h1);
    rd(ALO_STAT_OFS, {30'h0, dst_exp, 1'b0});
    xfer(1'b0, 12'h100, 32'h0, 4'hf, 32'h0, 1'b1);
    $display("test refusals done");
    summarize();
  end

  // Watchdog, well beyond the expected couple of thousand cycles
  initial begin
    #80000;
    err_total++;
    summarize();
  end
endmodule // acc_add_and_logic_ops_tb_top
